// ### aux_seq_defs.svh
// Register offsets, field positions, reset values and input codes for the step configuration bank
`ifndef AUX_SEQ_DEFS_SVH
`define AUX_SEQ_DEFS_SVH

// ==========================================================
// Register indices and byte addresses
`define STEP_TWO_INDEX      8'h92
`define STEP_THREE_INDEX    8'h93
`define STEP_TWO_ADDR       12'h248
`define STEP_THREE_ADDR     12'h24C

// ==========================================================
// Field positions
`define ENABLE_BIT          15
`define GAIN_HI             14
`define GAIN_LO             13
`define NEG_BIT             4
`define POS_HI              3
`define POS_LO              0

// ==========================================================
// Reset values
`define STEP_TWO_RESET      16'h0002
`define STEP_THREE_RESET    16'h0003
`define WRITABLE_MASK       16'hE01F

// ==========================================================
// Positive input codes
`define POS_TEMP_SENSOR     4'h8
`define POS_GROUND_SHORT    4'h9
`define POS_TEST_DAC        4'hA

`endif

// ### aux_seq_pkg.sv
// Types shared by the step configuration bank
package aux_seq_pkg;

	typedef enum logic [1:0]
	{
		gain_one  = 2'b00,
		gain_two  = 2'b01,
		gain_four = 2'b10
	} gain_e;

	typedef enum logic [1:0]
	{
		neg_ground    = 2'b00,
		neg_input_7   = 2'b01,
		neg_automatic = 2'b10
	} negative_e;

	typedef struct packed
	{
		logic [15:0] step_two;
		logic [15:0] step_three;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} bank_s;

endpackage

// ### step_decode.sv
// Decodes one sequencer step configuration word into routing and gain
`timescale 1ns/100ps
`default_nettype none
`include "aux_seq_defs.svh"

module step_decode
(
	input  wire logic [15:0]                config_word,
	output var  logic                       enable,
	output var  aux_seq_pkg::gain_e         gain,
	output var  logic [2:0]                 gain_factor,
	output var  aux_seq_pkg::negative_e     negative,
	output var  logic [3:0]                 positive,
	output var  logic                       external_positive
);

	// ==========================================================
	// Decode
	always_comb
	begin
		enable = config_word[`ENABLE_BIT];
		positive = config_word[`POS_HI:`POS_LO];
		external_positive = ~config_word[`POS_HI];
		case (config_word[`GAIN_HI:`GAIN_LO])
			2'h0:
			begin
				gain = aux_seq_pkg::gain_one;
				gain_factor = 3'h1;
			end
			2'h1:
			begin
				gain = aux_seq_pkg::gain_two;
				gain_factor = 3'h2;
			end
			default:
			begin
				gain = aux_seq_pkg::gain_four;
				gain_factor = 3'h4;
			end
		endcase
		// Codes 8 and up pick their own negative side; the select bit is ignored
		if (config_word[`POS_HI])
			negative = aux_seq_pkg::neg_automatic;
		else if (config_word[`NEG_BIT])
			negative = aux_seq_pkg::neg_input_7;
		else
			negative = aux_seq_pkg::neg_ground;
	end

endmodule // step_decode
`default_nettype wire

// ### aux_seq_step_bank.sv
// APB register bank for sequencer steps two and three of the auxiliary converter
// Function
// - Step two bit 15 enables the step
// - Gain codes 00,01,1x give 1,2,4
// - Bit 4 selects ground or input seven; codes 8 and up route the negative side automatically and ignore bit 4
// - Positive codes 0-7 pick external inputs
// - Codes 8,9,A: temperature, short, test DAC
// - Step two at 92h, resets 0002h
// - Step three at 93h, resets 0003h
// - Step three bit 15 enables the step
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "aux_seq_defs.svh"

module aux_seq_step_bank
(
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [11:0]                paddr,
	input  wire logic [31:0]                pwdata,
	input  wire logic [3:0]                 pstrb,
	output var  logic [31:0]                prdata,
	output var  logic                       pready,
	output var  logic                       pslverr,
	output var  logic                       step_two_enable,
	output var  logic [1:0]                 step_two_gain,
	output var  logic                       step_two_negative_select,
	output var  logic [3:0]                 step_two_positive_select,
	output var  logic                       step_three_enable,
	output var  logic [1:0]                 step_three_gain,
	output var  logic                       step_three_negative_select,
	output var  logic [3:0]                 step_three_positive_select,
	output var  aux_seq_pkg::negative_e     step_two_negative_route,
	output var  aux_seq_pkg::negative_e     step_three_negative_route,
	output var  logic [2:0]                 step_two_gain_factor,
	output var  logic [2:0]                 step_three_gain_factor
);

	// ==========================================================
	// State
	aux_seq_pkg::bank_s                     state;
	aux_seq_pkg::bank_s                     next_state;
	logic                                   setup;
	logic                                   hit_two;
	logic                                   hit_three;
	logic [15:0]                            lane_mask;
	aux_seq_pkg::negative_e                 route_two;
	aux_seq_pkg::negative_e                 route_three;
	logic [2:0]                             factor_two;
	logic [2:0]                             factor_three;
	aux_seq_pkg::negative_e                 route_two_q;
	aux_seq_pkg::negative_e                 route_three_q;
	logic [2:0]                             factor_two_q;
	logic [2:0]                             factor_three_q;

	// ==========================================================
	// Bus decode
	// Answer in the access phase's first cycle: zero wait states
	assign setup     = psel & ~penable;
	assign hit_two   = (paddr == `STEP_TWO_ADDR);
	assign hit_three = (paddr == `STEP_THREE_ADDR);
	assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}} & `WRITABLE_MASK;

	always_comb
	begin
		next_state = state;
		next_state.pready = 1'b0;
		next_state.pslverr = 1'b0;
		if (setup)
		begin
			next_state.pready = 1'b1;
			next_state.prdata = 32'h0000_0000;
			if (!hit_two && !hit_three)
				next_state.pslverr = 1'b1;  // Unmapped words error out
			else if (pwrite)
			begin
				if (hit_two)
					next_state.step_two = (state.step_two & ~lane_mask) | (pwdata[15:0] & lane_mask);
				else
					next_state.step_three = (state.step_three & ~lane_mask) | (pwdata[15:0] & lane_mask);
			end
			else if (hit_two)
				next_state.prdata = {16'h0000, state.step_two & `WRITABLE_MASK};
			else
				next_state.prdata = {16'h0000, state.step_three & `WRITABLE_MASK};
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state.step_two   <= `STEP_TWO_RESET;
			state.step_three <= `STEP_THREE_RESET;
			state.prdata     <= 32'h0000_0000;
			state.pready     <= 1'b0;
			state.pslverr    <= 1'b0;
		end
		else
			state <= next_state;
	end

	// ==========================================================
	// Step decode
	step_decode u_decode_two
	(
		.config_word       (next_state.step_two),
		.enable            (),
		.gain              (),
		.gain_factor       (factor_two),
		.negative          (route_two),
		.positive          (),
		.external_positive ()
	);

	step_decode u_decode_three
	(
		.config_word       (next_state.step_three),
		.enable            (),
		.gain              (),
		.gain_factor       (factor_three),
		.negative          (route_three),
		.positive          (),
		.external_positive ()
	);

	// Decoded views are registered so every output comes from a flip-flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			route_two_q    <= aux_seq_pkg::neg_ground;
			route_three_q  <= aux_seq_pkg::neg_ground;
			factor_two_q   <= 3'h1;
			factor_three_q <= 3'h1;
		end
		else
		begin
			route_two_q    <= route_two;
			route_three_q  <= route_three;
			factor_two_q   <= factor_two;
			factor_three_q <= factor_three;
		end
	end

	// ==========================================================
	// Outputs
	assign prdata                     = state.prdata;
	assign pready                     = state.pready;
	assign pslverr                    = state.pslverr;
	assign step_two_enable            = state.step_two[`ENABLE_BIT];
	assign step_two_gain              = state.step_two[`GAIN_HI:`GAIN_LO];
	assign step_two_negative_select   = state.step_two[`NEG_BIT];
	assign step_two_positive_select   = state.step_two[`POS_HI:`POS_LO];
	assign step_three_enable          = state.step_three[`ENABLE_BIT];
	assign step_three_gain            = state.step_three[`GAIN_HI:`GAIN_LO];
	assign step_three_negative_select = state.step_three[`NEG_BIT];
	assign step_three_positive_select = state.step_three[`POS_HI:`POS_LO];
	assign step_two_negative_route    = route_two_q;
	assign step_three_negative_route  = route_three_q;
	assign step_two_gain_factor       = factor_two_q;
	assign step_three_gain_factor     = factor_three_q;

endmodule // aux_seq_step_bank
`default_nettype wire

// ### aux_seq_step_bank_assertions.sv
// Checker for the step configuration bank
`timescale 1ns/100ps
`default_nettype none
module aux_seq_step_bank_assertions
(
	input wire logic		pclk,
	input wire logic		presetn,
	input wire logic		psel,
	input wire logic		penable,
	input wire logic		pwrite,
	input wire logic [11:0]		paddr,
	input wire logic [31:0]		pwdata,
	input wire logic [3:0]		pstrb,
	input wire logic [31:0]		prdata,
	input wire logic		pready,
	input wire logic		pslverr,
	input wire logic		step_two_enable,
	input wire logic [1:0]		step_two_gain,
	input wire logic		step_two_negative_select,
	input wire logic [3:0]		step_two_positive_select,
	input wire logic		step_three_enable,
	input wire aux_seq_pkg::negative_e	step_two_negative_route,
	input wire logic [2:0]		step_two_gain_factor
);
	// ==========================================================
	// Helpers
	logic	setup;
	logic	w2;
	assign setup = psel && !penable;
	assign w2 = setup && pwrite && paddr == 12'h248;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// ==========================================================
	// Properties
	property p_err; setup && paddr != 12'h248 && paddr != 12'h24C |=> pslverr && prdata == 32'h0; endproperty
	a_err: assert property (p_err) else $error("unmapped access not refused");
	property p_rsv; pready |-> prdata[31:16] == 16'h0 && prdata[12:5] == 8'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
	property p_rd2; pready && !pwrite && paddr == 12'h248 |-> prdata[15:0] == {step_two_enable,
		step_two_gain, 8'h00, step_two_negative_select, step_two_positive_select}; endproperty
	a_rd2: assert property (p_rd2) else $error("step two readback wrong");
	property p_en2; w2 && pstrb[1] |=> step_two_enable == $past(pwdata[15]); endproperty
	a_en2: assert property (p_en2) else $error("step two enable not written");
	property p_pos2; w2 && pstrb[0] |=> step_two_positive_select == $past(pwdata[3:0]); endproperty
	a_pos2: assert property (p_pos2) else $error("positive select not written");
	property p_gain; step_two_gain_factor == (step_two_gain == 2'h0 ? 3'h1 : step_two_gain == 2'h1 ? 3'h2 : 3'h4); endproperty
	a_gain: assert property (p_gain) else $error("gain factor wrong");
	property p_auto; step_two_positive_select[3] |-> step_two_negative_route == aux_seq_pkg::neg_automatic; endproperty
	a_auto: assert property (p_auto) else $error("internal source route wrong");
	property p_hold3; $changed(step_three_enable) |-> $past(setup && pwrite && paddr == 12'h24C && pstrb[1]); endproperty
	a_hold3: assert property (p_hold3) else $error("step three enable changed unwritten");
endmodule // aux_seq_step_bank_assertions
bind aux_seq_step_bank aux_seq_step_bank_assertions i_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .step_two_enable(step_two_enable), .step_two_gain(step_two_gain),
	.step_two_negative_select(step_two_negative_select), .step_two_positive_select(step_two_positive_select),
	.step_three_enable(step_three_enable), .step_two_negative_route(step_two_negative_route),
	.step_two_gain_factor(step_two_gain_factor));
`default_nettype wire

// ### aux_seq_step_bank_test.sv
// Testbench for the step configuration bank
`timescale 1ns/100ps
`default_nettype none
module aux_seq_step_bank_test;
	// ==========================================================
	// Signals
	logic		pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [11:0]	paddr;
	logic [31:0]	pwdata, prdata, rd;
	logic [3:0]	pstrb, ps2, ps3;
	logic		en2, ng2, en3, ng3;
	logic [1:0]	ga2, ga3, rt2, rt3;
	logic [2:0]	gf2, gf3;
	int		failures, compares, cycles;
	aux_seq_step_bank i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.step_two_enable(en2), .step_two_gain(ga2), .step_two_negative_select(ng2),
		.step_two_positive_select(ps2), .step_three_enable(en3), .step_three_gain(ga3),
		.step_three_negative_select(ng3), .step_three_positive_select(ps3), .step_two_negative_route(rt2),
		.step_three_negative_route(rt3), .step_two_gain_factor(gf2), .step_three_gain_factor(gf3));
	// ==========================================================
	// Tasks
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	// Request stands until pready is sampled high; read data is taken at that same edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		@(posedge pclk);
		{psel, penable, pwrite, paddr, pwdata, pstrb} <= {2'b10, w, a, d, s};
		@(posedge pclk);
		penable <= 1'b1;
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		{psel, penable} <= 2'b00;
	endtask
	task automatic t_reset;
		apb(0, 12'h248, 0, 0);
		chk("step two reset", 32'h2, rd);
		apb(0, 12'h24C, 0, 0);
		chk("step three reset", 32'h3, rd);
		chk("enables", 0, {en2, en3});
		chk("positive reset", 32'h23, {ps2, ps3});
		chk("route reset", 0, rt2);
		chk("gain factor reset", 32'h9, {gf2, gf3});
	endtask
	task automatic t_gain;
		for (int g = 0; g < 4; g++)
		begin
			apb(1, 12'h248, 32'hFFFF9FE5 | (g << 13), 4'h3);
			chk("gain factor", g == 0 ? 1 : g == 1 ? 2 : 4, gf2);
			chk("gain field", g, ga2);
			apb(0, 12'h248, 0, 0);
			chk("readback", 32'h8005 | (g << 13), rd);
		end
	endtask
	task automatic t_pos;
		for (int p = 0; p < 11; p++)
		begin
			apb(1, 12'h248, 32'h10 | p, 4'h3);
			chk("route", p < 8 ? 1 : 2, rt2);
			chk("positive", p, ps2);
			chk("negative select", 1, ng2);
		end
		apb(1, 12'h248, 32'h1, 4'h3);
		chk("ground route", 0, rt2);
		apb(1, 12'h248, 32'h9, 4'h3);
		chk("short route", 2, rt2);
	endtask
	task automatic t_three;
		apb(1, 12'h24C, 32'hA017, 4'h1);
		apb(0, 12'h24C, 0, 0);
		chk("lane zero only", 32'h17, rd);
		apb(1, 12'h24C, 32'hA017, 4'h3);
		chk("step three fields", 32'hB7, {en3, ga3, ng3, ps3});
		chk("step three route", 1, rt3);
		chk("step three gain factor", 2, gf3);
		apb(1, 12'h24C, 32'hA, 4'h3);
		chk("step three internal", 2, rt3);
		apb(0, 12'h250, 0, 0);
		chk("unmapped data", 0, rd);
		chk("unmapped error", 1, er);
		apb(1, 12'h250, 32'hFFFF, 4'h3);
		chk("unmapped write error", 1, er);
		apb(0, 12'h24C, 0, 0);
		chk("unmapped write ignored", 32'hA, rd);
	endtask
	task automatic results;
		$display("failures %0d compares %0d", failures, compares);
		if (failures == 0 && compares > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ==========================================================
	// Clock, timeout and main sequence
	initial
	begin
		pclk = 0;
		forever #12.5 pclk = ~pclk;
	end
	always @(posedge pclk)
	begin
		cycles <= cycles + 1;
		if (cycles == 2000)
		begin
			failures++;
			results();
		end
	end
	initial
	begin
		{presetn, psel, penable, pwrite, paddr, pwdata, pstrb} = 0;
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_gain();
		t_pos();
		t_three();
		results();
	end
endmodule // aux_seq_step_bank_test
`default_nettype wire
